// ### tb.sv
/* Self-checking bench for wdt_core.
   Assumes wdt_pkg is compiled first; the bench drives all ports. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH %0t bad value", $time); end end
module tb;
  import wdt_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       por_resetn = 1'b0;
  logic       peripheral_enable = 1'b0;
  logic       sfr_wr = 1'b0;
  logic       chk_req = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic       cpu_reset_req;
  logic [7:0] exp_q[$];
  int         error_cnt = 0;
  int         total_checks = 0;
  int         seed = 63324;
  int         n;
  int         req_cnt = 0;
  always #2.5 ref_clk = ~ref_clk;
  wdt_core i_dut (.ref_clk(ref_clk), .resetn(resetn), .por_resetn(por_resetn),
    .peripheral_enable(peripheral_enable), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_reset_req(cpu_reset_req));
  // Count request cycles so silent phases can be judged
  always @(posedge ref_clk) if (cpu_reset_req === 1'b1) req_cnt++;
  // Compare the oldest note once the image has settled
  always @(negedge ref_clk) if (chk_req === 1'b1) `CHK(sfr_rdata, exp_q.pop_front())
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask
  // Two edges of slack cover the registered read image
  task automatic rd(input logic [7:0] e);
    repeat (2) @(posedge ref_clk);
    exp_q.push_back(e);
    chk_req <= 1'b1;
    @(posedge ref_clk);
    chk_req <= 1'b0;
  endtask
  task automatic wait_req(input int lim);
    n = 0;
    while (cpu_reset_req !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Run needs about 70000 cycles; this cuts a hang short at 90000
  initial begin
    #450000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    por_resetn <= 1'b1;
    rd(8'h00);
    wr(cfg_offset ^ (8'($random(seed)) | 8'h01), 8'($random(seed)));
    rd(8'h00);
    $display("Test reset and stray write done");
    wr(cfg_offset, 8'h02);
    wr(cfg_offset, 8'h03);
    rd(8'h00);
    // Disabled block must stay silent well past one period
    repeat (20000) @(posedge ref_clk);
    `CHK(req_cnt, 0)
    peripheral_enable <= 1'b1;
    wait_req(2 * 16384 + 100);
    `CHK(n >= 16000 && n < 2 * 16384 + 100, 1'b1)
    repeat (8) @(posedge ref_clk);
    rd(8'h02);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(8'h02);
    wr(cfg_offset, 8'h00);
    rd(8'h02);
    wr(cfg_offset, 8'h02);
    rd(8'h00);
    $display("Test watchdog expiry done");
    req_cnt = 0;
    wr(cfg_offset, 8'h16);
    wr(cfg_offset, 8'h17);
    rd(8'h14);
    n = 0;
    while (sfr_rdata[3] !== 1'b1 && n < 3 * 16384 + 100) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(n >= 32000 && n < 3 * 16384 + 100, 1'b1)
    rd(8'h1c);
    `CHK(req_cnt, 0)
    $display("Test timer mode done");
    end_sim();
  end
endmodule
`default_nettype wire

// ### wdt_core.sv
/*
  Watchdog timer with timer mode, top level. Holds watchdog_config and the
  restart sequence, and drives the processor reset request.
  Assumes a single ref_clk, synchronous active-low resetn, and a simple
  special-function bus: sfr_addr, sfr_wr with sfr_wdata, sfr_rdata combined
  by the processor. The system reset does not clear the expiry flag, so the
  caller must route the watchdog's own reset through resetn only via
  por_resetn for that flag.
*/
// Overview of operation
// - Timeout counter uses 14-bit system-clock prescaler.
// - Watchdog mode: unrestarted overflow resets processor.
// - Timeout select lives in bits 7:4.
// - Sixteen codes map to fixed period values.
// - Code zero unsupported in timer mode.
// - Timeout may deviate about 200 us.
// - Timer mode expiry sets overflow flag, bit 3.
// - Bit 2 selects watchdog or plain timer.
// - Any mode-bit write clears the counter.
// - Bit 1 expiry flag; write one clears.
// - Restart needs write bit0 clear then set.
// - New timeout select applies only on restart.
// - Timer mode never resets nor interrupts.
`timescale 1ns/10ps
`default_nettype none
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       por_resetn,
  input  wire logic       peripheral_enable,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            cpu_reset_req
);
  logic [3:0] timeout_select;
  logic [3:0] active_select;
  logic       timer_mode_select;
  logic       timer_overflow_flag;
  logic       expiry_flag;
  seq_t       seq;
  logic [2:0] pulse_cnt;
  logic [3:0] next_timeout_select;
  logic [3:0] next_active_select;
  logic       next_timer_mode_select;
  logic       next_timer_overflow_flag;
  logic       next_expiry_flag;
  seq_t       next_seq;
  logic [2:0] next_pulse_cnt;
  logic [7:0] next_sfr_rdata;
  logic       next_cpu_reset_req;
  logic       cfg_wr;
  logic       restart;
  logic       clear_count;
  logic       tick;
  logic       expire;
  logic       running;

  assign cfg_wr = sfr_wr && (sfr_addr == cfg_offset);

  // Restart only on a set-bit write right after a clear-bit write
  assign restart     = cfg_wr && sfr_wdata[restart_bit] && (seq == seq_armed);
  assign clear_count = restart || cfg_wr;
  // Code zero in timer mode is refused: the counter is held idle
  assign running     = peripheral_enable && !(timer_mode_select && active_select == 4'h0);

  // Register, sequence and reset-request next values
  always_comb begin
    next_timeout_select      = timeout_select;
    next_active_select       = active_select;
    next_timer_mode_select   = timer_mode_select;
    next_timer_overflow_flag = timer_overflow_flag;
    next_expiry_flag         = expiry_flag;
    next_seq                 = seq;
    next_pulse_cnt           = pulse_cnt;
    next_cpu_reset_req       = 1'b0;
    if (cfg_wr) begin
      next_timeout_select    = sfr_wdata[sel_hi:sel_lo];
      next_timer_mode_select = sfr_wdata[mode_bit];
      next_seq               = sfr_wdata[restart_bit] ? seq_idle : seq_armed;
      if (sfr_wdata[expiry_bit]) begin
        next_expiry_flag = 1'b0;
      end
      if (sfr_wdata[tovf_bit]) begin
        next_timer_overflow_flag = 1'b0;
      end
    end
    if (restart) begin
      next_active_select = sfr_wdata[sel_hi:sel_lo];
    end
    // A same-cycle expiry wins over a clearing write
    if (expire && running) begin
      if (timer_mode_select) begin
        next_timer_overflow_flag = 1'b1;
      end else begin
        next_expiry_flag = 1'b1;
        next_pulse_cnt   = 3'(reset_pulse_cyc);
      end
    end else if (pulse_cnt != 3'h0) begin
      next_pulse_cnt = pulse_cnt - 3'h1;
    end
    if (pulse_cnt != 3'h0 || (expire && running && !timer_mode_select)) begin
      next_cpu_reset_req = 1'b1;
    end
    next_sfr_rdata = {next_timeout_select, next_timer_overflow_flag,
                      next_timer_mode_select, next_expiry_flag, 1'b0};
  end

  // Expiry flag lives on power-on reset only, so it tells the reset cause
  always_ff @(posedge ref_clk) begin
    if (!por_resetn) begin
      expiry_flag <= 1'b0;
    end else begin
      expiry_flag <= next_expiry_flag;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      timeout_select      <= cfg_reset[sel_hi:sel_lo];
      active_select       <= cfg_reset[sel_hi:sel_lo];
      timer_mode_select   <= cfg_reset[mode_bit];
      timer_overflow_flag <= cfg_reset[tovf_bit];
      seq                 <= seq_idle;
      pulse_cnt           <= 3'h0;
      cpu_reset_req       <= 1'b0;
      // Image keeps the expiry flag through a system reset so the cause stays visible
      sfr_rdata           <= {cfg_reset[7:2], expiry_flag && por_resetn, 1'b0};
    end else begin
      timeout_select      <= next_timeout_select;
      active_select       <= next_active_select;
      timer_mode_select   <= next_timer_mode_select;
      timer_overflow_flag <= next_timer_overflow_flag;
      seq                 <= next_seq;
      pulse_cnt           <= next_pulse_cnt;
      cpu_reset_req       <= next_cpu_reset_req;
      sfr_rdata           <= next_sfr_rdata;
    end
  end

  // Prescaler restarts with the counter so the jitter stays within one prescaler wrap
  wdt_prescaler #(
    .width(prescale_width)
  ) u_prescaler (
    .ref_clk(ref_clk),
    .resetn (resetn),
    .enable (running),
    .clear  (clear_count),
    .tick   (tick)
  );

  wdt_period_counter #(
    .width(period_width)
  ) u_period (
    .ref_clk(ref_clk),
    .resetn (resetn),
    .load   (clear_count),
    .start  (period_start(restart ? sfr_wdata[sel_hi:sel_lo] : active_select)),
    .tick   (tick),
    .expire (expire)
  );
endmodule
`default_nettype wire

// ### wdt_core_props.sv
/* Port checker for wdt_core.
   Assumes it is bound onto wdt_core and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module wdt_core_chk
  import wdt_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       por_resetn,
  input wire logic       peripheral_enable,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       cpu_reset_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Write taken at the config address
  sequence s_cfg_wr;
    sfr_wr && sfr_addr == cfg_offset;
  endsequence
  // Disabled and untouched long enough for the tick pipeline to drain
  sequence s_idle_off;
    (!peripheral_enable && !sfr_wr)[*3];
  endsequence
  // Flag survives the system reset; only power-on reset or a write of one clears it
  property p_flag_kept;
    @(posedge ref_clk) disable iff (!por_resetn) (!resetn && sfr_rdata[1]) |=> sfr_rdata[1];
  endproperty
  a_bit0_zero: assert property (sfr_rdata[0] == 1'b0) else $error("restart bit read as one");
  a_sel_written: assert property (s_cfg_wr |=> sfr_rdata[7:4] == $past(sfr_wdata[7:4])) else $error("bad select");
  a_mode_written: assert property (s_cfg_wr |=> sfr_rdata[2] == $past(sfr_wdata[2])) else $error("bad mode");
  a_flag_cleared: assert property (s_cfg_wr ##0 sfr_wdata[1] |=> $rose(cpu_reset_req) || !sfr_rdata[1])
    else $error("expiry flag not cleared");
  a_zero_keeps: assert property (s_cfg_wr ##0 (!sfr_wdata[1] && sfr_rdata[1]) |=> sfr_rdata[1])
    else $error("expiry flag lost");
  a_pulse_len: assert property ($rose(cpu_reset_req) |-> cpu_reset_req[*5] ##1 !cpu_reset_req)
    else $error("reset pulse length wrong");
  a_pulse_flag: assert property ($rose(cpu_reset_req) |-> ##[0:1] sfr_rdata[1]) else $error("flag not set");
  a_timer_silent: assert property (sfr_rdata[2] && $past(sfr_rdata[2]) |-> !$rose(cpu_reset_req))
    else $error("reset in timer mode");
  a_quiet_off: assert property (s_idle_off |=> !$rose(cpu_reset_req) && !$rose(sfr_rdata[3]))
    else $error("expiry while disabled");
  a_ovf_timer: assert property ($rose(sfr_rdata[3]) |-> sfr_rdata[2]) else $error("overflow outside timer");
  a_flag_kept: assert property (p_flag_kept) else $error("flag cleared by system reset");
endmodule
bind wdt_core wdt_core_chk i_chk (.ref_clk(ref_clk), .resetn(resetn), .por_resetn(por_resetn),
  .peripheral_enable(peripheral_enable), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .cpu_reset_req(cpu_reset_req));
`default_nettype wire

// ### wdt_period_counter.sv
/*
  Period counter: loads a start value and counts up on each prescaler tick;
  raises a one-cycle expire pulse when it wraps past all ones.
  Assumes load and tick come from the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module wdt_period_counter
  import wdt_pkg::*;
#(
  parameter int width = period_width
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             load,
  input  wire logic [width-1:0] start,
  input  wire logic             tick,
  output logic                  expire
);
  logic [width-1:0] count;
  logic [width-1:0] next_count;
  logic             next_expire;

  // Reload on restart; wrap means the period has run out
  always_comb begin
    next_count  = count;
    next_expire = 1'b0;
    if (load) begin
      next_count = start;
    end else if (tick) begin
      next_count  = count + 1'b1;
      next_expire = &count;
      if (&count) begin
        next_count = start;   // Timer mode repeats with the same period
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count  <= '0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      expire <= next_expire;
    end
  end
endmodule
`default_nettype wire

// ### wdt_pkg.sv
/*
  Shared constants for the watchdog timer with timer mode: the configuration
  register layout, its reset value, the period table and the timing figures.
  Assumes a single 200 MHz system clock.
*/
`default_nettype none
package wdt_pkg;
  localparam logic [7:0] cfg_offset     = 8'h91;   // Special-function address of watchdog_config
  localparam logic [7:0] cfg_reset      = 8'h00;
  localparam int         sel_hi         = 7;       // timeout_select field
  localparam int         sel_lo         = 4;
  localparam int         tovf_bit       = 3;       // timer_overflow_flag
  localparam int         mode_bit       = 2;       // timer_mode_select
  localparam int         expiry_bit     = 1;       // expiry_flag
  localparam int         restart_bit    = 0;
  localparam int         prescale_width = 14;
  localparam int         period_width   = 14;
  localparam int         clk_mhz        = 200;
  localparam int         tolerance_us   = 200;     // Allowed deviation of any timeout
  localparam int         tolerance_cyc  = tolerance_us * clk_mhz;
  localparam int         reset_pulse_cyc = 4;      // Processor reset pulse lasts one cycle more than this

  typedef enum logic [1:0] {
    seq_idle  = 2'b00,
    seq_armed = 2'b01
  } seq_t;

  // Start value of the period counter for each timeout_select code
  function automatic logic [13:0] period_start(input logic [3:0] code);
    case (code)
      4'h0:    period_start = 14'h3fff;
      4'h1:    period_start = 14'h3ffe;
      4'h2:    period_start = 14'h3ffd;
      4'h3:    period_start = 14'h3ffb;
      4'h4:    period_start = 14'h3ff4;
      4'h5:    period_start = 14'h3fe8;
      4'h6:    period_start = 14'h3fcf;
      4'h7:    period_start = 14'h3f86;
      4'h8:    period_start = 14'h3f49;
      4'h9:    period_start = 14'h3f0c;
      4'ha:    period_start = 14'h3e9e;
      4'hb:    period_start = 14'h3b3b;
      4'hc:    period_start = 14'h38d9;
      4'hd:    period_start = 14'h3677;
      4'he:    period_start = 14'h2364;
      default: period_start = 14'h0000;
    endcase
  endfunction
endpackage
`default_nettype wire

// ### wdt_prescaler.sv
/*
  14-bit gated prescaler giving one enable pulse per full wrap.
  Assumes ref_clk is the active system clock; clear restarts it.
*/
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int width = prescale_width
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic enable,
  input  wire logic clear,
  output logic      tick
);
  logic [width-1:0] count;
  logic [width-1:0] next_count;
  logic             next_tick;

  // Count while enabled, pulse on the wrap
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (enable) begin
      next_count = count + 1'b1;
      next_tick  = &count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule
`default_nettype wire
